// [verilog/fsp_map.svh]
// register offsets, reset values, duty levels and timing counts
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
`define FSP_CLK_HZ 125000000
`define FSP_CLK_MHZ 125
`define FSP_A_MIN_SPEED 16'h0100
`define FSP_A_MAX_SPEED 16'h0101
`define FSP_A_MIN_DUTY 16'h0102
`define FSP_A_MAX_DUTY 16'h0103
`define FSP_A_LIMIT 16'h0109
`define FSP_A_RAMP 16'h0110
`define FSP_A_STATUS 16'h0111
`define FSP_RST_MIN_SPEED 8'h01
`define FSP_RST_MAX_SPEED 8'hFF
`define FSP_RST_MIN_DUTY 8'h00
`define FSP_RST_MAX_DUTY 8'hFF
`define FSP_RST_LIMIT 8'h00
`define FSP_RST_RAMP 8'h00
`define FSP_B_FULL 2
`define FSP_F_STOP 3:0
`define FSP_B_END 0
`define FSP_F_DUR 3:1
`define FSP_B_EXIT 4
`define FSP_DUTY_ONE 11'h400
`define FSP_DUTY_START 11'h029
`define FSP_DUTY_END_LO 11'h0F6
`define FSP_DUTY_END_HI 11'h333
`define FSP_PWM_OUT_HZ 48000
`define FSP_PWM_PERIOD (`FSP_CLK_HZ / `FSP_PWM_OUT_HZ)
`define FSP_SKIP_RPM 304
`define FSP_EXIT_RPM 16'h01F4
`define FSP_EXIT_PCT 97
`define FSP_MIN_HALL_CYCLES 8
`define FSP_POLE_PAIRS 2
`define FSP_SPEED_K (64'd60 * `FSP_CLK_HZ / `FSP_POLE_PAIRS)
`define FSP_SKIP_PERIOD (`FSP_SPEED_K / `FSP_SKIP_RPM)
`define FSP_RAMP_HI_US0 150000
`define FSP_RAMP_HI_US1 760000
`define FSP_RAMP_HI_US2 1510000
`define FSP_RAMP_HI_US3 2280000
`define FSP_RAMP_HI_US4 3040000
`define FSP_RAMP_HI_US5 4560000
`define FSP_RAMP_HI_US6 7600000
`define FSP_RAMP_HI_US7 15200000
`define FSP_RAMP_LO_US0 200
`define FSP_RAMP_LO_US1 480000
`define FSP_RAMP_LO_US2 960000
`define FSP_RAMP_LO_US3 1500000
`define FSP_RAMP_LO_US4 2000000
`define FSP_RAMP_LO_US5 3000000
`define FSP_RAMP_LO_US6 5000000
`define FSP_RAMP_LO_US7 10000000
`define FSP_SPAN_HI (`FSP_DUTY_END_HI - `FSP_DUTY_START)
`define FSP_SPAN_LO (`FSP_DUTY_END_LO - `FSP_DUTY_START)
`define FSP_STEP(us, span) 32'((64'(us) * `FSP_CLK_MHZ) / (span))
`endif

// [verilog/fsp_pkg.sv]
// types of the fan speed profile block
package fsp_pkg;
   typedef enum logic [2:0] {MODE_CHECK = 3'h1, MODE_SOFT = 3'h2,
      MODE_RUN = 3'h4} fsp_mode_type;
   typedef enum logic [2:0] {OP_DUTY = 3'h1, OP_CURVE = 3'h2,
      OP_SPEED = 3'h4} fsp_op_type;
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } fsp_reg_req_type;
   typedef struct packed {
      logic [7:0] min_speed;
      logic [7:0] max_speed;
      logic [7:0] min_duty;
      logic [7:0] max_duty;
      logic [7:0] limit;
      logic [7:0] ramp;
   } fsp_cfg_type;
   typedef struct packed {
      fsp_cfg_type cfg;
      logic [7:0] rdata;
      logic pos_s1, pos_s2, neg_s1, neg_s2, hall_lvl, hall_d;
      logic pwm_s1, pwm_s2, pwm_d;
      logic [23:0] hall_cnt, hall_period;
      logic [3:0] hall_edges;
      logic [23:0] in_cnt, in_high, in_period, in_hi_lat;
      fsp_op_type op;
      logic busy;
      logic [3:0] idx;
      logic [39:0] rem;
      logic [23:0] den;
      logic [15:0] quo;
      logic [7:0] duty8;
      logic [15:0] speed, target;
      logic force_full;
      fsp_mode_type mode;
      logic [10:0] duty;
      logic [31:0] step_cnt;
      logic signed [31:0] integ;
      logic [11:0] pwm_cnt;
      logic drive_pos, drive_neg, tach_low;
   } fsp_state_type;
endpackage

// [verilog/fsp_speed_profile.sv]
// soft start ramp, duty to speed curve and speed loop of a fan driver
// Functional notes
// - already above 304 rpm: skip soft start
// - soft start begins at 4% duty
// - end duty select: 24% or 80%
// - ramp from start to end duty
// - ramp rises linearly with equal steps
// - three-bit code picks ramp duration
// - exit on end duty or exit speed
// - exit speed: 97% of target or 500 rpm
// - soft start lasts at least 8 hall cycles
// - after soft start run closed loop
// - hall level picks drive current direction
// - PI loop tracks target from input duty
// - input PWM 25 Hz to 100 kHz measured
// - output PWM fixed at 48 kHz
// - speed codes set curve end points
// - minimum speed code decodes by fixed table
// - min and max input duty registers
// - bit 2 picks over-maximum behaviour
// - bits 3:0 pick under-minimum behaviour
// - linear speed between the duty limits
// - duty code means code over 255
// - over max: hold max speed or 100%
`include "fsp_map.svh"
module fsp_speed_profile #(
   parameter logic [11:0] PWM_PERIOD = 12'(`FSP_PWM_PERIOD),
   parameter logic [23:0] SKIP_PERIOD = 24'(`FSP_SKIP_PERIOD),
   parameter logic [31:0] STEP_HI [0:7] = '{
      `FSP_STEP(`FSP_RAMP_HI_US0, `FSP_SPAN_HI),
      `FSP_STEP(`FSP_RAMP_HI_US1, `FSP_SPAN_HI),
      `FSP_STEP(`FSP_RAMP_HI_US2, `FSP_SPAN_HI),
      `FSP_STEP(`FSP_RAMP_HI_US3, `FSP_SPAN_HI),
      `FSP_STEP(`FSP_RAMP_HI_US4, `FSP_SPAN_HI),
      `FSP_STEP(`FSP_RAMP_HI_US5, `FSP_SPAN_HI),
      `FSP_STEP(`FSP_RAMP_HI_US6, `FSP_SPAN_HI),
      `FSP_STEP(`FSP_RAMP_HI_US7, `FSP_SPAN_HI)},
   parameter logic [31:0] STEP_LO [0:7] = '{
      `FSP_STEP(`FSP_RAMP_LO_US0, `FSP_SPAN_LO),
      `FSP_STEP(`FSP_RAMP_LO_US1, `FSP_SPAN_LO),
      `FSP_STEP(`FSP_RAMP_LO_US2, `FSP_SPAN_LO),
      `FSP_STEP(`FSP_RAMP_LO_US3, `FSP_SPAN_LO),
      `FSP_STEP(`FSP_RAMP_LO_US4, `FSP_SPAN_LO),
      `FSP_STEP(`FSP_RAMP_LO_US5, `FSP_SPAN_LO),
      `FSP_STEP(`FSP_RAMP_LO_US6, `FSP_SPAN_LO),
      `FSP_STEP(`FSP_RAMP_LO_US7, `FSP_SPAN_LO)},
   parameter int P_SHIFT = 4,
   parameter int I_SHIFT = 12
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire fsp_pkg::fsp_reg_req_type reg_req_in,
   output logic [7:0] reg_rdata_out,
   input wire logic pwm_cmd_in,
   input wire logic hall_input_pos_in,
   input wire logic hall_input_neg_in,
   output logic drive_pos_out,
   output logic drive_neg_out,
   output logic tach_output_out,
   output logic tach_output_oe_out
);
   import fsp_pkg::*;

   if (PWM_PERIOD < 12'h002 || P_SHIFT > 16 || I_SHIFT > 16 ||
       I_SHIFT < 1)
   begin : g_check
      $error("fsp_speed_profile: unsupported parameter value");
   end

   fsp_state_type st, next_st;
   logic [10:0] end_duty;
   logic speed_ok;

   // minimum speed code table, piecewise linear
   function automatic logic [15:0] min_rpm(input logic [7:0] c);
      logic [15:0] w;
      w = {8'h00, c};
      if (c == 8'h00)
         min_rpm = 16'h0000;
      else if (c <= 8'h53)
         min_rpm = 16'(300 + 10 * (w - 16'h0001));
      else if (c <= 8'h93)
         min_rpm = 16'(1120 + 20 * (w - 16'h0053));
      else if (c <= 8'hCB)
         min_rpm = 16'(2400 + 50 * (w - 16'h0093));
      else
         min_rpm = 16'(5200 + 100 * (w - 16'h00CB));
   endfunction

   // maximum speed code table, piecewise linear
   function automatic logic [15:0] max_rpm(input logic [7:0] c);
      logic [15:0] w;
      w = {8'h00, c};
      if (c <= 8'h29)
         max_rpm = 16'(300 + 20 * w);
      else if (c <= 8'h49)
         max_rpm = 16'(1120 + 40 * (w - 16'h0029));
      else if (c <= 8'h65)
         max_rpm = 16'(2400 + 100 * (w - 16'h0049));
      else
         max_rpm = 16'(5200 + 200 * (w - 16'h0065));
   endfunction

   assign end_duty = st.cfg.ramp[`FSP_B_END] ? `FSP_DUTY_END_HI :
      `FSP_DUTY_END_LO;
   assign speed_ok = st.cfg.ramp[`FSP_B_EXIT] ?
      (st.speed >= `FSP_EXIT_RPM) :
      (st.target != 16'h0000 && 24'(st.speed) * 24'd100 >=
       24'(st.target) * 24'(`FSP_EXIT_PCT));

   always_comb
   begin
      logic hall_rise, pwm_rise, tick, pwm_on;
      logic [39:0] num, dsh;
      logic [7:0] span, stop_th, th5;
      logic [15:0] rpm_l, rpm_h;
      logic [31:0] step_len;
      logic signed [17:0] err;
      logic signed [31:0] ni, pv;
      hall_rise = 1'b0;
      pwm_rise = 1'b0;
      tick = 1'b0;
      pwm_on = 1'b0;
      num = 40'h0;
      dsh = 40'h0;
      span = 8'h00;
      stop_th = 8'h00;
      th5 = 8'h00;
      rpm_l = min_rpm(st.cfg.min_speed);
      rpm_h = max_rpm(st.cfg.max_speed);
      step_len = 32'h0;
      err = 18'sh0;
      ni = 32'sh0;
      pv = 32'sh0;
      next_st = st;
      // register port
      if (reg_req_in.wr)
      begin
         case (reg_req_in.addr)
            `FSP_A_MIN_SPEED: next_st.cfg.min_speed = reg_req_in.wdata;
            `FSP_A_MAX_SPEED: next_st.cfg.max_speed = reg_req_in.wdata;
            `FSP_A_MIN_DUTY: next_st.cfg.min_duty = reg_req_in.wdata;
            `FSP_A_MAX_DUTY: next_st.cfg.max_duty = reg_req_in.wdata;
            `FSP_A_LIMIT: next_st.cfg.limit = reg_req_in.wdata;
            `FSP_A_RAMP: next_st.cfg.ramp = reg_req_in.wdata;
            default: next_st.cfg = st.cfg;
         endcase
      end
      case (reg_req_in.addr)
         `FSP_A_MIN_SPEED: next_st.rdata = st.cfg.min_speed;
         `FSP_A_MAX_SPEED: next_st.rdata = st.cfg.max_speed;
         `FSP_A_MIN_DUTY: next_st.rdata = st.cfg.min_duty;
         `FSP_A_MAX_DUTY: next_st.rdata = st.cfg.max_duty;
         `FSP_A_LIMIT: next_st.rdata = st.cfg.limit;
         `FSP_A_RAMP: next_st.rdata = st.cfg.ramp;
         `FSP_A_STATUS: next_st.rdata = {4'h0, st.force_full, st.mode};
         default: next_st.rdata = 8'h00;
      endcase
      // pin synchronisers
      next_st.pos_s1 = hall_input_pos_in;
      next_st.pos_s2 = st.pos_s1;
      next_st.neg_s1 = hall_input_neg_in;
      next_st.neg_s2 = st.neg_s1;
      next_st.pwm_s1 = pwm_cmd_in;
      next_st.pwm_s2 = st.pwm_s1;
      next_st.pwm_d = st.pwm_s2;
      if (st.pos_s2 != st.neg_s2)
         next_st.hall_lvl = st.pos_s2;
      next_st.hall_d = st.hall_lvl;
      hall_rise = st.hall_lvl && !st.hall_d;
      pwm_rise = st.pwm_s2 && !st.pwm_d;
      // hall period per electrical cycle
      if (hall_rise)
      begin
         next_st.hall_period = st.hall_cnt;
         next_st.hall_cnt = 24'h000000;
         if (st.hall_edges != 4'hF)
            next_st.hall_edges = st.hall_edges + 4'h1;
      end
      else if (st.hall_cnt == 24'hFFFFFF)
         next_st.hall_period = 24'hFFFFFF;
      else
         next_st.hall_cnt = st.hall_cnt + 24'h000001;
      // input high time and period, stuck level after timeout
      if (pwm_rise)
      begin
         next_st.in_period = st.in_cnt;
         next_st.in_hi_lat = st.in_high;
         next_st.in_cnt = 24'h000000;
         next_st.in_high = 24'h000000;
      end
      else if (st.in_cnt == 24'hFFFFFF)
      begin
         next_st.in_period = 24'hFFFFFF;
         next_st.in_hi_lat = st.pwm_s2 ? 24'hFFFFFF : 24'h000000;
      end
      else
      begin
         next_st.in_cnt = st.in_cnt + 24'h000001;
         if (st.pwm_s2)
            next_st.in_high = st.in_high + 24'h000001;
      end
      // shared serial divider: duty, curve, speed in turn
      span = st.cfg.max_duty - st.cfg.min_duty;
      if (!st.busy)
      begin
         case (st.op)
            OP_DUTY:
            begin
               num = 40'(st.in_hi_lat) * 40'd255;
               next_st.den = (st.in_period == 24'h0) ? 24'h000001 :
                  st.in_period;
            end
            OP_CURVE:
            begin
               num = 40'(rpm_h - rpm_l) *
                  40'(8'(st.duty8 - st.cfg.min_duty));
               next_st.den = (span == 8'h00) ? 24'h000001 : 24'(span);
            end
            OP_SPEED:
            begin
               num = 40'(`FSP_SPEED_K);
               next_st.den = st.hall_period;
            end
            default: num = 40'h0;
         endcase
         next_st.rem = num;
         next_st.quo = 16'h0000;
         next_st.idx = 4'hF;
         next_st.busy = 1'b1;
         if (num >= {next_st.den, 16'h0000})
         begin
            next_st.quo = 16'hFFFF;
            next_st.idx = 4'h0;
            next_st.rem = 40'h0;
         end
      end
      else
      begin
         dsh = 40'(st.den) << st.idx;
         if (st.rem >= dsh)
         begin
            next_st.rem = st.rem - dsh;
            next_st.quo[st.idx] = 1'b1;
         end
         if (st.idx == 4'h0)
         begin
            next_st.busy = 1'b0;
            case (st.op)
               OP_DUTY:
               begin
                  next_st.duty8 = next_st.quo[7:0];
                  next_st.op = OP_CURVE;
               end
               OP_CURVE:
               begin
                  th5 = 8'(5 * st.cfg.limit[`FSP_F_STOP]);
                  stop_th = (st.cfg.limit[`FSP_F_STOP] == 4'hF ||
                     st.cfg.min_duty < th5) ? st.cfg.min_duty : th5;
                  next_st.force_full = 1'b0;
                  if (st.duty8 > st.cfg.max_duty)
                  begin
                     next_st.target = rpm_h;
                     next_st.force_full =
                        st.cfg.limit[`FSP_B_FULL];
                  end
                  else if (st.duty8 >= st.cfg.min_duty)
                     next_st.target = rpm_l + next_st.quo;
                  else if (st.cfg.limit[`FSP_F_STOP] != 4'h0 &&
                     st.duty8 < stop_th)
                     next_st.target = 16'h0000;
                  else
                     next_st.target = rpm_l;
                  next_st.op = OP_SPEED;
               end
               OP_SPEED:
               begin
                  next_st.speed = (st.den == 24'hFFFFFF) ? 16'h0000 :
                     next_st.quo;
                  next_st.op = OP_DUTY;
               end
               default: next_st.op = OP_DUTY;
            endcase
         end
         else
            next_st.idx = st.idx - 4'h1;
      end
      // fixed output carrier
      tick = (st.pwm_cnt == PWM_PERIOD - 12'h001);
      next_st.pwm_cnt = tick ? 12'h000 : st.pwm_cnt + 12'h001;
      step_len = st.cfg.ramp[`FSP_B_END] ? STEP_HI[st.cfg.ramp[`FSP_F_DUR]]
         : STEP_LO[st.cfg.ramp[`FSP_F_DUR]];
      case (st.mode)
         MODE_CHECK:
         begin
            if (hall_rise && st.hall_edges >= 4'h2 && // reset rise may be false
               st.hall_cnt <= SKIP_PERIOD)
            begin
               next_st.mode = MODE_RUN;
               next_st.integ = 32'sh0;
            end
            else if (st.hall_cnt > SKIP_PERIOD)
            begin
               next_st.mode = MODE_SOFT;
               next_st.duty = `FSP_DUTY_START;
               next_st.step_cnt = 32'h0;
               next_st.hall_edges = 4'h0;
            end
         end
         MODE_SOFT:
         begin
            if (st.duty < end_duty)
            begin
               if (st.step_cnt + 32'h1 >= step_len)
               begin
                  next_st.duty = st.duty + 11'h001;
                  next_st.step_cnt = 32'h0;
               end
               else
                  next_st.step_cnt = st.step_cnt + 32'h1;
            end
            if ((st.duty >= end_duty || speed_ok) &&
               st.hall_edges >= 4'(`FSP_MIN_HALL_CYCLES))
            begin
               next_st.mode = MODE_RUN;
               next_st.integ = 32'(st.duty) <<< I_SHIFT;
            end
         end
         MODE_RUN:
         begin
            if (st.force_full)
               next_st.duty = `FSP_DUTY_ONE;
            else if (st.target == 16'h0000)
            begin
               next_st.duty = 11'h000;
               next_st.integ = 32'sh0;
            end
            else if (tick)
            begin
               err = $signed({2'b00, st.target}) -
                  $signed({2'b00, st.speed});
               ni = st.integ + 32'(err);
               if (ni < 32'sh0)
                  ni = 32'sh0;
               else if (ni > (32'(`FSP_DUTY_ONE) <<< I_SHIFT))
                  ni = 32'(`FSP_DUTY_ONE) <<< I_SHIFT;
               pv = (ni >>> I_SHIFT) + (32'(err) >>> P_SHIFT);
               if (pv < 32'sh0)
                  pv = 32'sh0;
               else if (pv > 32'(`FSP_DUTY_ONE))
                  pv = 32'(`FSP_DUTY_ONE);
               next_st.integ = ni;
               next_st.duty = 11'(pv);
            end
         end
         default: next_st.mode = MODE_CHECK;
      endcase
      pwm_on = ({st.pwm_cnt, 10'h000} < 22'(st.duty) * 22'(PWM_PERIOD));
      next_st.drive_pos = pwm_on && st.hall_lvl;
      next_st.drive_neg = pwm_on && !st.hall_lvl;
      next_st.tach_low = !st.hall_lvl;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         st <= '0;
         st.cfg <= {`FSP_RST_MIN_SPEED, `FSP_RST_MAX_SPEED,
            `FSP_RST_MIN_DUTY, `FSP_RST_MAX_DUTY, `FSP_RST_LIMIT,
            `FSP_RST_RAMP};
         st.op <= OP_DUTY;
         st.mode <= MODE_CHECK;
      end
      else
         st <= next_st;
   end

   assign reg_rdata_out = st.rdata;
   assign drive_pos_out = st.drive_pos;
   assign drive_neg_out = st.drive_neg;
   assign tach_output_out = 1'b0;
   assign tach_output_oe_out = st.tach_low;

   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);

   sequence s_soft_exit;
      st.mode == MODE_SOFT ##1 st.mode == MODE_RUN;
   endsequence

   a_skip_fast: assert property (
      $past(st.mode) == MODE_CHECK && st.mode == MODE_RUN |->
      $past(st.hall_cnt) <= SKIP_PERIOD)
      else $error("soft start skipped below skip speed");
   a_start_duty: assert property (
      $past(st.mode) == MODE_CHECK && st.mode == MODE_SOFT |->
      st.duty == `FSP_DUTY_START)
      else $error("soft start did not begin at start duty");
   a_ramp_bound: assert property (
      st.mode == MODE_SOFT |-> st.duty <= end_duty)
      else $error("ramp duty beyond end duty");
   a_ramp_step: assert property (
      st.mode == MODE_SOFT ##1 st.mode == MODE_SOFT |->
      st.duty - $past(st.duty) <= 11'h001)
      else $error("ramp step larger than one unit");
   a_exit_cause: assert property (
      s_soft_exit |-> $past(st.duty) >= $past(end_duty) ||
      $past(speed_ok))
      else $error("soft start left without exit condition");
   a_min_cycles: assert property (
      s_soft_exit |-> $past(st.hall_edges) >= 4'(`FSP_MIN_HALL_CYCLES))
      else $error("soft start shorter than minimum hall cycles");
   a_soft_next: assert property (
      st.mode == MODE_SOFT |=> st.mode inside {MODE_SOFT, MODE_RUN})
      else $error("soft start left to a mode other than run");
   a_drive_dir: assert property (
      drive_pos_out |-> $past(st.hall_lvl) && !drive_neg_out)
      else $error("drive direction disagrees with hall level");
   a_carrier_wrap: assert property (
      st.pwm_cnt == PWM_PERIOD - 12'h001 |=> st.pwm_cnt == 12'h000)
      else $error("output carrier period wrong");
   a_full_duty: assert property (
      st.mode == MODE_RUN && st.force_full ##1 st.mode == MODE_RUN |->
      st.duty == `FSP_DUTY_ONE)
      else $error("over-maximum full duty not applied");
   a_stop_zero: assert property (
      st.mode == MODE_RUN && !st.force_full && st.target == 16'h0000
      |=> st.duty == 11'h000)
      else $error("stop target did not zero the duty");
endmodule

// [tb/fsp_host_motor.sv]
// host speed command source and hall sensed motor model
module fsp_host_motor (
   input wire logic clk_sys_in,
   input wire logic [31:0] hall_half_in,
   input wire logic [31:0] pwm_period_in,
   input wire logic [31:0] pwm_high_in,
   output logic pwm_cmd_out,
   output logic hall_pos_out,
   output logic hall_neg_out
);
   timeunit 1ns;
   timeprecision 100ps;
   int hc = 0;
   int pc = 0;
   initial
   begin
      pwm_cmd_out = 1'b0;
      hall_pos_out = 1'b0;
      hall_neg_out = 1'b1;
      forever
      begin
         @(posedge clk_sys_in);
         #1;
         pc = (pc + 1 >= pwm_period_in) ? 0 : pc + 1;
         pwm_cmd_out = pc < pwm_high_in;
         // rotor stands still while the half period is zero
         if (hall_half_in > 0)
            hc++;
         if (hall_half_in > 0 && hc >= hall_half_in)
         begin
            hc = 0;
            hall_pos_out = ~hall_pos_out;
            hall_neg_out = ~hall_pos_out;
         end
      end
   end
endmodule

// [tb/fsp_speed_profile_bench.sv]
// self-checking bench of the fan speed profile block
module fsp_speed_profile_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import fsp_pkg::*;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   fsp_reg_req_type reg_req = '0;
   logic [7:0] rdata;
   logic pwm, hpos, hneg, dpos, dneg, tach, tach_oe;
   logic [31:0] hall_half = '0;
   logic [31:0] pwm_per = 32'h64;
   logic [31:0] pwm_hi = 32'h32;
   int num_errors = 0;
   int n_checks = 0;
   int mdl [int];
   int cnt;
   logic [7:0] v;
   logic [15:0] at [8] = '{16'h0100, 16'h0101, 16'h0102, 16'h0103,
      16'h0109, 16'h0110, 16'h0200, 16'h0111};
   logic [2:0] code_tab [2] = '{3'h7, 3'h0};
   fsp_speed_profile #(.SKIP_PERIOD(24'h7D0),
      .STEP_HI('{32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h1388}),
      .STEP_LO('{32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h1388})
   ) i_fsp_speed_profile (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .reg_req_in(reg_req), .reg_rdata_out(rdata), .pwm_cmd_in(pwm),
      .hall_input_pos_in(hpos), .hall_input_neg_in(hneg),
      .drive_pos_out(dpos), .drive_neg_out(dneg),
      .tach_output_out(tach), .tach_output_oe_out(tach_oe));
   fsp_host_motor i_fsp_host_motor (.clk_sys_in(clk_sys_in),
      .hall_half_in(hall_half), .pwm_period_in(pwm_per),
      .pwm_high_in(pwm_hi), .pwm_cmd_out(pwm), .hall_pos_out(hpos),
      .hall_neg_out(hneg));
   initial
   begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   task automatic final_report();
      if (num_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_in(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi)
      begin
         num_errors++;
         $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   function automatic logic [7:0] exp_of(input int a);
      return mdl.exists(a) ? 8'(mdl[a]) : 8'h00;
   endfunction
   task automatic do_reset();
      srst_in = 1'b1;
      repeat (12) @(posedge clk_sys_in);
      #1 srst_in = 1'b0;
      mdl = '{32'h100: 1, 32'h101: 255, 32'h102: 0, 32'h103: 255,
         32'h109: 0, 32'h110: 0, 32'h111: 1};
   endtask
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] dt);
      reg_req = '{1'b1, a, dt};
      @(posedge clk_sys_in);
      #1 reg_req.wr = 1'b0;
      @(posedge clk_sys_in);
      #1;
      if (a inside {[16'h0100:16'h0103], 16'h0109, 16'h0110})
         mdl[a] = dt;
   endtask
   task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
      reg_req = '{1'b0, a, 8'h00};
      @(posedge clk_sys_in);
      #1 chk(rdata, e);
   endtask
   // poll the status register until the mode shows up or time runs out
   task automatic wait_mode(input logic [7:0] m);
      cnt = 0;
      reg_req = '{1'b0, 16'h0111, 8'h00};
      @(posedge clk_sys_in);
      #1;
      while (rdata !== m && cnt < 20000)
      begin
         @(posedge clk_sys_in);
         #1 cnt++;
      end
      mdl[32'h111] = m;
   endtask
   // drive direction and tach level checked 10 clocks after each hall edge
   task automatic hall_edges(input int n);
      repeat (n)
      begin
         @(posedge hpos);
         repeat (10) @(posedge clk_sys_in);
         #1 chk({tach_oe, dneg, tach}, 8'h00);
         @(negedge hpos);
         repeat (10) @(posedge clk_sys_in);
         #1 chk({tach_oe, dpos, tach}, 8'h04);
      end
   endtask
   task automatic count_on();
      cnt = 0;
      repeat (2604)
      begin
         @(posedge clk_sys_in);
         #1;
         if ((dpos | dneg) === 1'b1)
            cnt++;
      end
   endtask
   initial
   begin
      repeat (95000) @(posedge clk_sys_in);
      num_errors++;
      final_report();
   end
   initial
   begin
      void'($urandom(32'h6209));
      do_reset();
      foreach (mdl[a])
         reg_rd(16'(a), exp_of(a));
      foreach (at[i])
      begin
         v = 8'($urandom);
         if (at[i] == 16'h0100)
            v = v & 8'h7F;
         if (at[i] == 16'h0101)
            v = v | 8'h80;
         reg_wr(at[i], v);
         reg_rd(at[i], exp_of(at[i]));
      end
      foreach (code_tab[k])
      begin
         do_reset();
         reg_wr(16'h0110, {3'h0, 1'(k), code_tab[k], 1'(k)});
         hall_half = 32'h4E2;
         wait_mode(8'h02);
         chk(rdata, exp_of(32'h111));
         if (k == 0)
         begin
            count_on();
            chk_in(cnt, 102, 107);
         end
         hall_edges(6);
         reg_rd(16'h0111, exp_of(32'h111));
         if (k == 1)
         begin
            count_on();
            chk_in(cnt, 2080, 2086);
         end
         hall_edges(4);
         if (k == 1)
            reg_rd(16'h0111, 8'h04);
      end
      hall_half = 32'h1F4;
      pwm_hi = 32'h63;
      do_reset();
      reg_wr(16'h0103, 8'h80);
      reg_wr(16'h0109, 8'h04);
      wait_mode(8'h0C);
      chk(rdata, exp_of(32'h111));
      hall_edges(2);
      count_on();
      chk_in(cnt, 2600, 2604);
      pwm_hi = 32'h5;
      reg_wr(16'h0102, 8'h40);
      reg_wr(16'h0109, 8'h0F);
      repeat (400) @(posedge clk_sys_in);
      reg_rd(16'h0111, 8'h04);
      count_on();
      chk_in(cnt, 0, 0);
      final_report();
   end
endmodule
